// file: design/tpw_pkg.sv
// Notes on behaviour
// R1: PWM exists only on the lower timer, resolution up to 8 bits.
// R2: PWM wave drives the upper timer's pin; upper timer stays a free 8-bit timer.
// R3: Output flip-flop toggles on compare match and on the 2^n overflow, n = 6, 7, 8.
// R4: Lower up-counter clears to zero on each 2^n overflow.
// R5: Software loads a compare value nonzero and below the overflow count.
// R6: With double buffer on, written compare waits in buffer until overflow.
// R7: Low time equals compare value times the prescaled tick period.
// R8: Stop before reconfiguring; stopping clears the counter; run restarts counting.
// R9: One flip-flop control write clears output, enables toggling and double buffer.
// R10: Software routes the shared port bit to the timer output function.
// R11: Period is overflow count times tick; ticks differ by 4; gear doubles period.
// R12: Mode 11 selects PWM; cycle codes 01, 10, 11 give 64, 128, 256.
// R13: Upper timer clock codes 01, 10, 11 pick fine, coarse, coarsest; no output.
// R14: Pin follows the output flip-flop directly, changing on the toggling tick.
package tpw_pkg;

  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;

  localparam logic [7:0]  OFS_RUN        = 8'h00;
  localparam logic [7:0]  OFS_MODE       = 8'h04;
  localparam logic [7:0]  OFS_LOWER_CMP  = 8'h08;
  localparam logic [7:0]  OFS_UPPER_CMP  = 8'h0c;
  localparam logic [7:0]  OFS_FF_CTRL    = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam logic [7:0]  OFS_CMP_BUF    = 8'h18;

  // Run register
  localparam int unsigned RUN_LOWER_BIT  = 0;
  localparam int unsigned RUN_UPPER_BIT  = 1;

  // Mode register fields
  localparam int unsigned MODE_SEL_LSB   = 0;
  localparam int unsigned CYCLE_SEL_LSB  = 2;
  localparam int unsigned UPPER_CLK_LSB  = 4;
  localparam int unsigned LOWER_CLK_LSB  = 6;

  // Flip-flop control fields
  localparam int unsigned FF_DBUF_BIT    = 0;
  localparam int unsigned FF_TOG_EN_BIT  = 1;
  localparam int unsigned FF_ACT_LSB     = 2;
  localparam logic [1:0]  FF_ACT_SET     = 2'h1;
  localparam logic [1:0]  FF_ACT_CLEAR   = 2'h2;

  // Status fields
  localparam int unsigned ST_LOWER_LSB   = 0;
  localparam int unsigned ST_UPPER_LSB   = 8;
  localparam int unsigned ST_FF_BIT      = 16;
  localparam int unsigned ST_UMATCH_BIT  = 17;

  localparam logic [1:0]  MODE_PWM       = 2'h3;
  localparam logic [1:0]  CYCLE_64       = 2'h1;
  localparam logic [1:0]  CYCLE_128      = 2'h2;
  localparam logic [1:0]  CYCLE_256      = 2'h3;
  localparam logic [1:0]  CLK_EXT        = 2'h0;
  localparam logic [1:0]  CLK_A          = 2'h1;
  localparam logic [1:0]  CLK_B          = 2'h2;
  localparam logic [1:0]  CLK_C          = 2'h3;

  // Prescaler divisions in system clocks at gear x1
  localparam int unsigned PRE_W          = 16;
  localparam int unsigned DIV_FINE       = 16;
  localparam int unsigned DIV_MIDDLE     = DIV_FINE * 4;
  localparam int unsigned DIV_COARSE     = DIV_MIDDLE * 4;
  localparam int unsigned DIV_COARSEST   = DIV_COARSE * 16;
  localparam logic [2:0]  GEAR_MAX       = 3'h4;

  localparam logic [7:0]  RST_BYTE       = 8'h00;

endpackage

// file: design/tpw_upper_timer.sv
module tpw_upper_timer
  import tpw_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_compare,
  output logic      [7:0] o_count,
  output logic            o_match
);

  logic [7:0] count_q;
  logic       match_q;

  // Plain interval timer: counts ticks, clears on match
  always_ff @(posedge i_clock or negedge i_nrst) begin // R2
    if (!i_nrst) begin
      count_q <= RST_BYTE;
    end else if (!i_run) begin
      count_q <= RST_BYTE;
    end else if (i_tick) begin
      if (count_q + 8'h01 == i_compare) begin
        count_q <= RST_BYTE;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= i_run && i_tick && (count_q + 8'h01 == i_compare);
    end
  end

  assign o_count = count_q;
  assign o_match = match_q;

endmodule

// file: design/tpw_pwm_top.sv
// Chosen here: register access over APB and the placing of the registers.
module tpw_pwm_top
  import tpw_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        i_clock_gear_select,
  input  wire logic              i_ext_count_clock,
  output logic                   o_timer_output_pin,
  output logic                   o_upper_match
);

  logic [1:0]        run_q;
  logic [7:0]        mode_q;
  logic [7:0]        cmp_active_q;
  logic [7:0]        cmp_buf_q;
  logic [7:0]        upper_cmp_q;
  logic              dbuf_en_q;
  logic              tog_en_q;
  logic              output_flipflop_q;
  logic              umatch_seen_q;
  logic [8:0]        lower_up_counter_q;
  logic [PRE_W-1:0]  pre_q;
  logic [2:0]        gear_s1_q;
  logic [2:0]        gear_q;
  logic [2:0]        gear_lim;
  logic              ext_s1_q;
  logic              ext_s2_q;
  logic              ext_s3_q;
  logic [DATA_W-1:0] prdata_q;

  logic              wr_acc;
  logic              rd_setup;
  logic              mapped;
  logic [1:0]        pair_mode_select;
  logic [1:0]        pwm_cycle_select;
  logic [1:0]        upper_clk_sel;
  logic [1:0]        lower_clk_sel;
  logic              pwm_mode;
  logic              lower_run;
  logic              fine_prescale_tick;
  logic              middle_prescale_tick;
  logic              coarse_prescale_tick;
  logic              coarsest_prescale_tick;
  logic              ext_tick;
  logic              lower_tick;
  logic              upper_tick;
  logic [8:0]        wrap_last;
  logic              overflow;
  logic              match;
  logic [7:0]        upper_count;
  logic              upper_match;
  logic [7:0]        wbyte;

  // Tick when the prescaler completes a span of div clocks scaled by the gear
  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt,
                                    input int unsigned      div,
                                    input logic [2:0]       gear);
    logic [PRE_W:0] span;
    span = PRE_W'(div) << gear;
    pre_tick = ((cnt & PRE_W'(span - 1)) == PRE_W'(span - 1));
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // APB decode
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped   = hit(paddr, OFS_RUN) || hit(paddr, OFS_MODE) ||
                    hit(paddr, OFS_LOWER_CMP) || hit(paddr, OFS_UPPER_CMP) ||
                    hit(paddr, OFS_FF_CTRL) || hit(paddr, OFS_STATUS) ||
                    hit(paddr, OFS_CMP_BUF);
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_q;
  assign wbyte    = pstrb[0] ? pwdata[7:0] : 8'h00;

  assign pair_mode_select = mode_q[MODE_SEL_LSB +: 2];
  assign pwm_cycle_select = mode_q[CYCLE_SEL_LSB +: 2];
  assign upper_clk_sel    = mode_q[UPPER_CLK_LSB +: 2];
  assign lower_clk_sel    = mode_q[LOWER_CLK_LSB +: 2];
  assign pwm_mode         = (pair_mode_select == MODE_PWM); // R12
  assign lower_run        = run_q[RUN_LOWER_BIT] && pwm_mode; // R1

  // Gear and external clock come from outside: two stages first
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      gear_s1_q <= 3'h0;
      gear_q    <= 3'h0;
    end else begin
      gear_s1_q <= i_clock_gear_select;
      gear_q    <= gear_s1_q;
    end
  end

  // Gears above the top step act as the top step
  assign gear_lim = (gear_q > GEAR_MAX) ? GEAR_MAX : gear_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_count_clock;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_tick = ext_s2_q && !ext_s3_q;

  // Prescaler runs while either timer runs
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_q <= '0;
    end else if (!run_q[RUN_LOWER_BIT] && !run_q[RUN_UPPER_BIT]) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  assign fine_prescale_tick     = pre_tick(pre_q, DIV_FINE, gear_lim); // R11
  assign middle_prescale_tick   = pre_tick(pre_q, DIV_MIDDLE, gear_lim); // R11
  assign coarse_prescale_tick   = pre_tick(pre_q, DIV_COARSE, gear_lim); // R11
  assign coarsest_prescale_tick = pre_tick(pre_q, DIV_COARSEST, gear_lim);

  always_comb begin
    case (lower_clk_sel)
      CLK_EXT: lower_tick = ext_tick;
      CLK_A:   lower_tick = fine_prescale_tick;
      CLK_B:   lower_tick = middle_prescale_tick;
      CLK_C:   lower_tick = coarse_prescale_tick;
      default: lower_tick = 1'b0;
    endcase
  end

  always_comb begin // R13
    case (upper_clk_sel)
      CLK_A:   upper_tick = fine_prescale_tick;
      CLK_B:   upper_tick = coarse_prescale_tick;
      CLK_C:   upper_tick = coarsest_prescale_tick;
      default: upper_tick = 1'b0;
    endcase
  end

  // Last count before the 2^n overflow
  always_comb begin // R12
    case (pwm_cycle_select)
      CYCLE_64:  wrap_last = 9'h03f;
      CYCLE_128: wrap_last = 9'h07f;
      CYCLE_256: wrap_last = 9'h0ff;
      default:   wrap_last = 9'h0ff;
    endcase
  end

  assign overflow = lower_run && lower_tick && (lower_up_counter_q == wrap_last); // R3
  // Match when the count reaches the compare value; value below 2^n assumed
  assign match    = lower_run && lower_tick &&
                    (lower_up_counter_q + 9'h001 == {1'b0, cmp_active_q}); // R3 R5 R7

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      lower_up_counter_q <= 9'h000;
    end else if (!lower_run) begin
      lower_up_counter_q <= 9'h000; // R8
    end else if (overflow) begin
      lower_up_counter_q <= 9'h000; // R4
    end else if (lower_tick) begin
      lower_up_counter_q <= lower_up_counter_q + 9'h001;
    end
  end

  // Run control
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= 2'h0;
    end else if (wr_acc && hit(paddr, OFS_RUN)) begin
      run_q <= wbyte[1:0]; // R8
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= RST_BYTE;
    end else if (wr_acc && hit(paddr, OFS_MODE)) begin
      mode_q <= wbyte;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      upper_cmp_q <= RST_BYTE;
    end else if (wr_acc && hit(paddr, OFS_UPPER_CMP)) begin
      upper_cmp_q <= wbyte;
    end
  end

  // Compare buffer and active compare
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_buf_q <= RST_BYTE;
    end else if (wr_acc && hit(paddr, OFS_LOWER_CMP)) begin
      cmp_buf_q <= wbyte; // R6
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_active_q <= RST_BYTE;
    end else if (wr_acc && hit(paddr, OFS_LOWER_CMP) && !dbuf_en_q) begin
      cmp_active_q <= wbyte;
    end else if (overflow && dbuf_en_q) begin
      cmp_active_q <= cmp_buf_q; // R6
    end
  end

  // Flip-flop control: toggle enable and double buffer enable
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      dbuf_en_q <= 1'b0;
      tog_en_q  <= 1'b0;
    end else if (wr_acc && hit(paddr, OFS_FF_CTRL)) begin
      dbuf_en_q <= wbyte[FF_DBUF_BIT]; // R9
      tog_en_q  <= wbyte[FF_TOG_EN_BIT]; // R9
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      output_flipflop_q <= 1'b0;
    end else if (wr_acc && hit(paddr, OFS_FF_CTRL) &&
                 wbyte[FF_ACT_LSB +: 2] == FF_ACT_CLEAR) begin
      output_flipflop_q <= 1'b0; // R9
    end else if (wr_acc && hit(paddr, OFS_FF_CTRL) &&
                 wbyte[FF_ACT_LSB +: 2] == FF_ACT_SET) begin
      output_flipflop_q <= 1'b1;
    end else if (tog_en_q && (match || overflow)) begin
      output_flipflop_q <= !output_flipflop_q; // R3 R7
    end
  end

  // Pin follows the flip-flop; port routing is outside this block
  assign o_timer_output_pin = output_flipflop_q; // R2 R10 R14

  tpw_upper_timer u_upper (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_run     (run_q[RUN_UPPER_BIT]),
    .i_tick    (upper_tick),
    .i_compare (upper_cmp_q),
    .o_count   (upper_count),
    .o_match   (upper_match)
  );

  assign o_upper_match = upper_match; // R13

  // Sticky upper match: hardware set wins over software clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      umatch_seen_q <= 1'b0;
    end else if (upper_match) begin
      umatch_seen_q <= 1'b1;
    end else if (wr_acc && hit(paddr, OFS_STATUS) && pwdata[ST_UMATCH_BIT]) begin
      umatch_seen_q <= 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= '0;
      case (paddr)
        OFS_RUN:       prdata_q[1:0] <= run_q;
        OFS_MODE:      prdata_q[7:0] <= mode_q;
        OFS_LOWER_CMP: prdata_q[7:0] <= cmp_active_q;
        OFS_UPPER_CMP: prdata_q[7:0] <= upper_cmp_q;
        OFS_FF_CTRL: begin
          prdata_q[FF_DBUF_BIT]   <= dbuf_en_q;
          prdata_q[FF_TOG_EN_BIT] <= tog_en_q;
        end
        OFS_STATUS: begin
          prdata_q[ST_LOWER_LSB +: 8] <= lower_up_counter_q[7:0];
          prdata_q[ST_UPPER_LSB +: 8] <= upper_count;
          prdata_q[ST_FF_BIT]         <= output_flipflop_q;
          prdata_q[ST_UMATCH_BIT]     <= umatch_seen_q;
        end
        OFS_CMP_BUF:   prdata_q[7:0] <= cmp_buf_q;
        default:       prdata_q <= '0;
      endcase
    end
  end

endmodule

// file: testbench/tpw_pwm_assertions.sv
module tpw_pwm_assertions
  import tpw_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        o_timer_output_pin,
  input wire logic        o_upper_match
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic       acc;
  logic       ffw;
  logic       bad_a;
  logic       stop_q;
  logic       ext_q;
  logic [1:0] cyc_q;
  logic [7:0] gap_q;
  assign acc = psel && penable;
  assign ffw = acc && pwrite && paddr == OFS_FF_CTRL;
  assign bad_a = paddr[1:0] != 2'h0 || paddr > OFS_CMP_BUF;
  // Cycles since the pin last moved
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) gap_q <= 8'h00;
    else if ($changed(o_timer_output_pin)) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_q <= 2'h0;
      ext_q <= 1'b1;
    end else if (acc && pwrite && paddr == OFS_MODE) begin
      cyc_q <= pwdata[3:2];
      ext_q <= (pwdata[7:6] == CLK_EXT);
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) stop_q <= 1'b1;
    else if (acc && pwrite && paddr == OFS_RUN) stop_q <= !pwdata[0];
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_st_rd;
    acc && !pwrite && paddr == OFS_STATUS;
  endsequence
  AST_PREADY: assert property (s_setup ##1 acc |-> pready)
    else $error("pready missing in access phase");
  AST_IDLE: assert property (!acc |-> !pready && !pslverr)
    else $error("answer outside access phase");
  AST_ERR_MAP: assert property (acc |-> pslverr == bad_a)
    else $error("pslverr does not follow address map");
  AST_ERR_RD: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_RD_WIDTH: assert property (acc && !pwrite |-> prdata[31:18] == 14'h0)
    else $error("unused read bits set");
  AST_MATCH_PULSE: assert property (o_upper_match |=> !o_upper_match)
    else $error("upper match longer than one cycle");
  AST_PIN_GAP: assert property ($changed(o_timer_output_pin) && !$past(ffw)
    && !$past(ffw, 2) |-> gap_q >= (ext_q ? 8'h02 : 8'h0f))
    else $error("pin toggled faster than one tick");
  AST_COUNT_WRAP: assert property (s_st_rd |-> cyc_q != CYCLE_64 || prdata[7:0] < 8'h40)
    else $error("counter passed 64 overflow");
  AST_STOP_ZERO: assert property (s_st_rd |-> !stop_q || prdata[7:0] == 8'h00)
    else $error("stopped counter not zero");
endmodule

// file: testbench/timer_pwm_8bit_mode_test.sv
module timer_pwm_8bit_mode_test
  import tpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tpw_reg_row_t;
  typedef struct {logic [1:0] c; logic [1:0] k; logic [2:0] g; logic [7:0] m; int t;} tpw_pwm_row_t;
  logic         i_clock = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0, ext = 0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, rdat;
  logic [2:0]   gear = 3'h0;
  logic         pready, pslverr, pin, umatch, rerr;
  int           bad_count = 0, num_checks = 0, cyc = 0, t0, t1, t2, per;
  tpw_reg_row_t rrows[6] = '{'{OFS_MODE, 32'hffff_ff5b, 32'h5b, 0},
    '{OFS_LOWER_CMP, 32'h5a, 32'h5a, 0}, '{OFS_UPPER_CMP, 32'hffff_ffa5, 32'ha5, 0},
    '{OFS_FF_CTRL, 32'h3, 32'h3, 0}, '{8'h1c, 32'h77, 32'h0, 1}, '{8'h02, 32'h77, 32'h0, 1}};
  tpw_pwm_row_t prows[6] = '{'{CYCLE_64, CLK_A, 3'h0, 8'h01, 16},
    '{CYCLE_128, CLK_A, 3'h0, 8'h5a, 16}, '{CYCLE_256, CLK_A, 3'h0, 8'hff, 16},
    '{CYCLE_64, CLK_A, 3'h1, 8'h3f, 32}, '{CYCLE_64, CLK_B, 3'h0, 8'h20, 64},
    '{CYCLE_64, CLK_EXT, 3'h0, 8'h04, 8}};
  int           udiv[3] = '{DIV_FINE, DIV_COARSE, DIV_COARSEST};

  tpw_pwm_top DUT (.i_clock(i_clock), .i_nrst(i_nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_clock_gear_select(gear), .i_ext_count_clock(ext),
    .o_timer_output_pin(pin), .o_upper_match(umatch));

  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  // External count clock rises every 8 system clocks
  initial begin
    forever begin
      repeat (4) @(posedge i_clock);
      ext <= ~ext;
    end
  end
  always @(posedge i_clock) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask
  task automatic wait_pin(input logic v, output int t);
    int n;
    n = 0;
    while (pin !== v && n < 20000) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 20000) chk({31'h0, pin}, {31'h0, v});
    t = cyc;
  endtask
  task automatic wait_match(output int t);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (umatch !== 1'b1 && n < 20000);
    chk({31'h0, umatch}, 32'h1);
    t = cyc;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge i_clock);
    bad_count++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    foreach (rrows[i]) begin
      wr(rrows[i].a, rrows[i].d);
      chk({31'h0, rerr}, {31'h0, rrows[i].e});
      rd(rrows[i].a, rrows[i].x);
    end
    $display("register table done");
    foreach (prows[i]) begin
      wr(OFS_RUN, 32'h0);
      gear <= prows[i].g;
      per = 64 << (prows[i].c - 1);
      wr(OFS_MODE, {24'h0, prows[i].k, 2'h0, prows[i].c, MODE_PWM});
      wr(OFS_FF_CTRL, 32'h0a);
      wr(OFS_LOWER_CMP, {24'h0, prows[i].m});
      wr(OFS_RUN, 32'h1);
      wait_pin(1'b1, t0);
      wait_pin(1'b0, t1);
      wait_pin(1'b1, t2);
      chk(32'(t2 - t1), 32'(prows[i].m * prows[i].t));
      chk(32'(t2 - t0), 32'(per * prows[i].t));
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rerr}, 32'h0);
      chk(32'(int'(rdat[7:0]) < per), 32'h1);
      chk({31'h0, rdat[16]}, 32'h1);
    end
    $display("pwm table done");
    wr(OFS_RUN, 32'h0);
    gear <= 3'h0;
    wr(OFS_MODE, {24'h0, CLK_A, 2'h0, CYCLE_64, MODE_PWM});
    wr(OFS_LOWER_CMP, 32'h0a);
    wr(OFS_FF_CTRL, 32'h0b);
    wr(OFS_RUN, 32'h1);
    wait_pin(1'b1, t0);
    wr(OFS_LOWER_CMP, 32'h28);
    rd(OFS_LOWER_CMP, 32'h0a);
    rd(OFS_CMP_BUF, 32'h28);
    rd(OFS_FF_CTRL, 32'h3);
    wait_pin(1'b0, t1);
    rd(OFS_LOWER_CMP, 32'h28);
    wait_pin(1'b1, t2);
    chk(32'(t2 - t1), 32'(40 * DIV_FINE));
    wr(OFS_FF_CTRL, 32'h0b);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rerr}, 32'h0);
    chk({31'h0, rdat[16]}, 32'h0);
    wr(OFS_RUN, 32'h0);
    rd(OFS_STATUS, 32'h0);
    repeat (100) @(posedge i_clock);
    chk({31'h0, pin}, 32'h0);
    $display("double buffer and stop done");
    for (int k = 1; k < 4; k++) begin
      wr(OFS_RUN, 32'h0);
      wr(OFS_MODE, {24'h0, CLK_A, 2'(k), CYCLE_64, MODE_PWM});
      wr(OFS_UPPER_CMP, 32'h2);
      wr(OFS_RUN, 32'h2);
      wait_match(t0);
      wait_match(t1);
      chk(32'(t1 - t0), 32'(2 * udiv[k - 1]));
      chk({31'h0, pin}, 32'h0);
    end
    wr(OFS_RUN, 32'h0);
    rd(OFS_STATUS, 32'h0002_0000);
    wr(OFS_STATUS, 32'h0002_0000);
    rd(OFS_STATUS, 32'h0);
    $display("upper timer done");
    wr(OFS_MODE, 32'h40);
    wr(OFS_RUN, 32'h1);
    repeat (64) @(posedge i_clock);
    rd(OFS_STATUS, 32'h0);
    $display("non-pwm mode done");
    wr(OFS_RUN, 32'h3);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0);
    $display("reset done");
    print_verdict;
  end
endmodule

bind tpw_pwm_top tpw_pwm_assertions u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .o_timer_output_pin(o_timer_output_pin),
  .o_upper_match(o_upper_match));
